// File: rtl/cpc_top.sv
`timescale 1ns/1ps
module cpc_top
  import cpc_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       cmd_en_in,
  input  wire logic [7:0] cmd_code_in,
  input  wire logic       ptr_load_in,
  input  wire logic       rd_step_in,
  input  wire logic [7:0] result_data_in,
  input  wire logic       scl_idle_pin_in,
  output logic [7:0]      rd_data_out,
  output logic [7:0]      ptr_out,
  output logic [3:0]      active_disable_out,
  output logic            timeout_en_out,
  output logic            timeout_check_out,
  output logic            byte_count_en_out,
  output logic            no_skip_out,
  output logic [3:0]      current_bipolar_en_out,
  output logic [3:0]      voltage_bipolar_en_out,
  output logic [3:0]      power_signed_out,
  output logic            snapshot_out,
  output logic            snapshot_reset_acc_out,
  output logic            data_ready_out
);
  typedef struct packed {
    logic [7:0]  chan_dis;
    logic [7:0]  bipolar;
    logic [3:0]  active_dis;
    logic [7:0]  rd_data;
    logic        snap;
    logic        snap_rst;
    logic [15:0] wait_cnt;
    logic        ready;
    logic        tmo_chk;
  } cpc_st_t;
  cpc_st_t    s_q;
  cpc_st_t    s_d;
  logic [7:0] ptr;
  logic       ptr_inact;
  logic       scl_idle;
  logic [7:0] fixed_one;
  // ----------------------------------------
  // reduced variants hold upper disables
  // ----------------------------------------
  // fixed disable bits
  assign fixed_one = (NUM_CHAN == 2) ? 8'h30 : (NUM_CHAN == 3) ? 8'h10 : 8'h00;
  cpc_sync u_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .d_in     (scl_idle_pin_in),
    .q_out    (scl_idle)
  );
  cpc_ptr u_ptr (
    .clock_in         (clock_in),
    .rst_n_in         (rst_n_in),
    .load_in          (ptr_load_in),
    .load_addr_in     (wr_addr_in),
    .step_in          (rd_step_in),
    .skip_en_in       (!s_q.chan_dis[CPC_BIT_NO_SKIP]),
    .inactive_in      (s_q.active_dis),
    .ptr_out          (ptr),
    .ptr_inactive_out (ptr_inact)
  );
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic is_snap;
    is_snap = 1'b0;
    s_d = s_q;
    s_d.snap     = 1'b0;
    s_d.snap_rst = 1'b0;
    // options and disables stored at once
    if (wr_en_in && wr_addr_in == CPC_ADDR_CHAN_DIS) begin
      s_d.chan_dis = (wr_data_in & 8'hfe) | fixed_one;
    end
    if (wr_en_in && wr_addr_in == CPC_ADDR_BIPOLAR) begin
      s_d.bipolar = wr_data_in;
    end
    if (cmd_en_in) begin
      is_snap = (cmd_code_in == CPC_ADDR_SNAP_STD) || (cmd_code_in == CPC_ADDR_SNAP_VOLT) ||
                (cmd_code_in == CPC_ADDR_BCAST_SNAP);
      s_d.snap_rst = (cmd_code_in != CPC_ADDR_SNAP_VOLT) && is_snap;
    end
    if (is_snap) begin
      s_d.active_dis = s_d.chan_dis[7:4];
      s_d.snap       = 1'b1;
      s_d.ready      = 1'b0;
      s_d.wait_cnt   = 16'(CPC_SNAP_WAIT_CYC - 1);
    end else if (!s_q.ready) begin
      if (s_q.wait_cnt == 16'h0000) begin
        s_d.ready = 1'b1;
      end else begin
        s_d.wait_cnt = s_q.wait_cnt - 16'h0001;
      end
    end
    if (ptr_inact && s_q.chan_dis[CPC_BIT_NO_SKIP]) begin
      s_d.rd_data = CPC_FF_BYTE;
    end else if (ptr == CPC_ADDR_CHAN_DIS) begin
      s_d.rd_data = s_q.chan_dis;
    end else if (ptr == CPC_ADDR_BIPOLAR) begin
      s_d.rd_data = s_q.bipolar;
    end else begin
      s_d.rd_data = result_data_in;
    end
    s_d.tmo_chk = s_q.chan_dis[CPC_BIT_TIMEOUT] && scl_idle;
  end
  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_q            <= '0;
      s_q.chan_dis   <= CPC_RST_CHAN_DIS | fixed_one;
      s_q.active_dis <= fixed_one[7:4];
      s_q.bipolar    <= CPC_RST_BIPOLAR;
      s_q.ready      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rd_data_out            = s_q.rd_data;
  assign ptr_out                = ptr;
  assign active_disable_out     = s_q.active_dis;
  assign timeout_en_out         = s_q.chan_dis[CPC_BIT_TIMEOUT];
  assign timeout_check_out      = s_q.tmo_chk;
  assign byte_count_en_out      = s_q.chan_dis[CPC_BIT_BYTE_COUNT];
  assign no_skip_out            = s_q.chan_dis[CPC_BIT_NO_SKIP];
  assign current_bipolar_en_out = s_q.bipolar[7:4];
  assign voltage_bipolar_en_out = s_q.bipolar[3:0];
  assign power_signed_out       = s_q.bipolar[7:4] | s_q.bipolar[3:0];
  assign snapshot_out           = s_q.snap;
  assign snapshot_reset_acc_out = s_q.snap_rst;
  assign data_ready_out         = s_q.ready;
endmodule

// File: rtl/cpc_pkg.sv
package cpc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] CPC_ADDR_CHAN_DIS  = 8'h1c;
  localparam logic [7:0] CPC_ADDR_BIPOLAR   = 8'h1d;
  localparam logic [7:0] CPC_ADDR_BCAST_SNAP = 8'h1e;
  localparam logic [7:0] CPC_ADDR_SNAP_STD  = 8'h00;
  localparam logic [7:0] CPC_ADDR_SNAP_VOLT = 8'h1f;
  // ----------------------------------------
  // result address range, shared by all channels, interleaved by address
  // ----------------------------------------
  localparam logic [7:0] CPC_ADDR_ACC_BASE   = 8'h03;
  localparam logic [7:0] CPC_ADDR_RES_LAST   = 8'h1a;
  localparam int         CPC_NUM_CHAN        = 4;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int         CPC_BIT_TIMEOUT     = 3;
  localparam int         CPC_BIT_BYTE_COUNT  = 2;
  localparam int         CPC_BIT_NO_SKIP     = 1;
  localparam logic [7:0] CPC_RST_CHAN_DIS    = 8'h00;
  localparam logic [7:0] CPC_RST_BIPOLAR     = 8'h00;
  localparam logic [7:0] CPC_FF_BYTE         = 8'hff;
  // ----------------------------------------
  // timing: host wait after snapshot
  // ----------------------------------------
  localparam int         CPC_CLK_MHZ         = 25;
  localparam int         CPC_SNAP_WAIT_US    = 1000;
  localparam int         CPC_SNAP_WAIT_CYC   = CPC_SNAP_WAIT_US * CPC_CLK_MHZ;
endpackage

// File: rtl/cpc_sync.sv
`timescale 1ns/1ps
module cpc_sync (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  typedef struct packed {
    logic [2:0] sh;
    logic       q;
  } cpc_sync_st_t;
  cpc_sync_st_t s_q;
  cpc_sync_st_t s_d;
  // first stage only feeds the second
  always_comb begin
    s_d    = s_q;
    s_d.sh = {s_q.sh[1:0], d_in};
    if (s_q.sh[2] == s_q.sh[1]) begin
      s_d.q = s_q.sh[2];
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign q_out = s_q.q;
endmodule

// File: rtl/cpc_ptr.sv
`timescale 1ns/1ps
module cpc_ptr
  import cpc_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       load_in,
  input  wire logic [7:0] load_addr_in,
  input  wire logic       step_in,
  input  wire logic       skip_en_in,
  input  wire logic [3:0] inactive_in,
  output logic [7:0]      ptr_out,
  output logic            ptr_inactive_out
);
  typedef struct packed {
    logic [7:0] ptr;
  } cpc_ptr_st_t;
  cpc_ptr_st_t s_q;
  cpc_ptr_st_t s_d;
  // channel that owns a result address, groups of four from the base
  function automatic logic owned_inactive(input logic [7:0] a, input logic [3:0] off);
    logic [7:0] rel;
    rel = a - CPC_ADDR_ACC_BASE;
    owned_inactive = (a >= CPC_ADDR_ACC_BASE) && (a <= CPC_ADDR_RES_LAST) && off[3 - rel[1:0]];
  endfunction
  always_comb begin
    logic [7:0] nxt;
    nxt = s_q.ptr;
    s_d = s_q;
    if (load_in) begin
      s_d.ptr = load_addr_in;
    end else if (step_in) begin
      nxt = s_q.ptr + 8'h01;
      for (int i = 0; i < CPC_NUM_CHAN; i++) begin
        if (skip_en_in && owned_inactive(nxt, inactive_in)) begin
          nxt = nxt + 8'h01;
        end
      end
      s_d.ptr = nxt;
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign ptr_out          = s_q.ptr;
  assign ptr_inactive_out = owned_inactive(s_q.ptr, inactive_in);
endmodule

// File: tb/cpc_top_checker.sv
`timescale 1ns/1ps
module cpc_top_checker
  import cpc_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       rst_n_in,
  input wire logic       wr_en_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic       cmd_en_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [3:0] active_disable_out,
  input wire logic       timeout_en_out,
  input wire logic       timeout_check_out,
  input wire logic       byte_count_en_out,
  input wire logic       no_skip_out,
  input wire logic [3:0] current_bipolar_en_out,
  input wire logic [3:0] voltage_bipolar_en_out,
  input wire logic [3:0] power_signed_out,
  input wire logic       snapshot_out,
  input wire logic       snapshot_reset_acc_out,
  input wire logic       data_ready_out
);
  logic snap_hit;
  // other codes must not apply pending disables
  assign snap_hit = cmd_en_in && cmd_code_in inside {CPC_ADDR_SNAP_STD, CPC_ADDR_SNAP_VOLT, CPC_ADDR_BCAST_SNAP};
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_wr(a); wr_en_in && wr_addr_in == a; endsequence
  sequence s_cmd(c); cmd_en_in && cmd_code_in == c; endsequence
  property p_opt; s_wr(CPC_ADDR_CHAN_DIS) |=>
    {timeout_en_out, byte_count_en_out, no_skip_out} == $past(wr_data_in[3:1]); endproperty
  a_opt: assert property (p_opt) else $error("option bits late");
  property p_hold; !snap_hit |=> $stable(active_disable_out); endproperty
  a_hold: assert property (p_hold) else $error("disables moved early");
  property p_bip; s_wr(CPC_ADDR_BIPOLAR) |=>
    {current_bipolar_en_out, voltage_bipolar_en_out} == $past(wr_data_in); endproperty
  a_bip: assert property (p_bip) else $error("range bits wrong");
  property p_sgn; power_signed_out == (current_bipolar_en_out | voltage_bipolar_en_out); endproperty
  a_sgn: assert property (p_sgn) else $error("power sign wrong");
  property p_tmo; !timeout_en_out [*2] |-> !timeout_check_out; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout while off");
  property p_bc; s_cmd(CPC_ADDR_BCAST_SNAP) |=> snapshot_out && snapshot_reset_acc_out && !data_ready_out; endproperty
  a_bc: assert property (p_bc) else $error("broadcast ignored");
  property p_vlt; s_cmd(CPC_ADDR_SNAP_VOLT) |=> snapshot_out && !snapshot_reset_acc_out; endproperty
  a_vlt: assert property (p_vlt) else $error("voltage snapshot wrong");
  property p_low; $fell(data_ready_out) |-> !data_ready_out [*8]; endproperty
  a_low: assert property (p_low) else $error("ready back too soon");
endmodule
bind cpc_top cpc_top_checker u_cpc_top_checker (.*);

// File: tb/cpc_result_bank.sv
`timescale 1ns/1ps
module cpc_result_bank (
  input  wire logic [7:0] addr_in,
  output logic [7:0]      data_out
);
  // rotated pattern: every location differs, so a wrong pointer shows
  assign data_out = {addr_in[3:0], addr_in[7:4]} ^ 8'h3c;
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cpc_pkg::*;
  logic       clock_in = 1'b0, rst_n_in = 1'b0, wr_en_in = 1'b0, cmd_en_in = 1'b0;
  logic       ptr_load_in = 1'b0, rd_step_in = 1'b0, scl_idle_pin_in = 1'b0;
  logic [7:0] wr_addr_in = 8'h00, wr_data_in = 8'h00, cmd_code_in = 8'h00;
  logic [7:0] result_data_in, rd_data_out, ptr_out, d, m_dis = 8'h00;
  logic [3:0] active_disable_out, current_bipolar_en_out, voltage_bipolar_en_out, power_signed_out;
  logic       timeout_en_out, timeout_check_out, byte_count_en_out, no_skip_out;
  logic       snapshot_out, snapshot_reset_acc_out, data_ready_out;
  logic [7:0] codes [3] = '{CPC_ADDR_SNAP_STD, CPC_ADDR_SNAP_VOLT, CPC_ADDR_BCAST_SNAP};
  int         err_total = 0;
  int         checked = 0;
  int         n;
  always #20 clock_in = ~clock_in;
  cpc_top u_cpc_top (.*);
  cpc_result_bank u_cpc_result_bank (.addr_in(ptr_out), .data_out(result_data_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock_in);
    s = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    wr_addr_in = a;
    wr_data_in = v;
    pulse(wr_en_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wr_addr_in = a;
    pulse(ptr_load_in);
    @(negedge clock_in);
    chk(rd_data_out, exp);
  endtask
  task automatic step(input logic [7:0] a, input logic [7:0] p, input logic [7:0] v);
    wr_addr_in = a;
    pulse(ptr_load_in);
    pulse(rd_step_in);
    chk(ptr_out, p);
    @(negedge clock_in);
    chk(rd_data_out, v);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    void'($urandom(32'h3ba5));
    repeat (2) @(negedge clock_in);
    rst_n_in = 1'b1;
    rd(CPC_ADDR_CHAN_DIS, 8'h00);
    rd(CPC_ADDR_BIPOLAR, 8'h00);
    chk(data_ready_out, 8'h01);
    for (int i = 0; i < 9; i++) begin
      d = 8'($urandom);
      scl_idle_pin_in = d[0];
      wr(CPC_ADDR_CHAN_DIS, d);
      chk({timeout_en_out, byte_count_en_out, no_skip_out}, d[3:1]);
      chk(active_disable_out, m_dis[7:4]);
      m_dis = d & 8'hfe;
      rd(CPC_ADDR_CHAN_DIS, m_dis);
      cmd_code_in = codes[i % 3];
      pulse(cmd_en_in);
      chk({snapshot_out, snapshot_reset_acc_out}, {1'b1, i % 3 != 1});
      chk(active_disable_out, m_dis[7:4]);
      d = 8'($urandom);
      wr(CPC_ADDR_BIPOLAR, d);
      chk({current_bipolar_en_out, voltage_bipolar_en_out}, d);
      chk(power_signed_out, d[7:4] | d[3:0]);
    end
    wr(CPC_ADDR_CHAN_DIS, 8'h08);
    scl_idle_pin_in = 1'b1;
    repeat (5) @(negedge clock_in);
    chk(timeout_check_out, 8'h01);
    wr(CPC_ADDR_CHAN_DIS, 8'h40);
    repeat (2) @(negedge clock_in);
    chk(timeout_check_out, 8'h00);
    cmd_code_in = CPC_ADDR_SNAP_STD;
    pulse(cmd_en_in);
    rd(8'h07, 8'h4c);
    step(8'h07, 8'h09, 8'hac);
    wr(CPC_ADDR_CHAN_DIS, 8'h42);
    step(8'h07, 8'h08, 8'hff);
    cmd_code_in = CPC_ADDR_BCAST_SNAP;
    pulse(cmd_en_in);
    n = 0;
    // host holds off reads until the refresh settles
    while (data_ready_out !== 1'b1 && n < 30000) begin
      @(negedge clock_in);
      n++;
    end
    chk({7'h00, n == CPC_SNAP_WAIT_CYC}, 8'h01);
    close_out();
  end
  initial begin
    #(40 * 40000);
    err_total++;
    close_out();
  end
endmodule
